/* File: sim/pms_power_mgmt_bench.sv */
`timescale 1ns/10ps
// Self-checking bench: register sequences, stop entry and wake, interrupt
module pms_power_mgmt_bench
  import pms_pkg::*;
;
  logic                  pclk;               // Bus clock, 40 ns
  logic                  presetn;            // Power-on reset, active low
  logic [PMS_ADDR_W-1:0] paddr;              // APB address
  logic                  psel;               // APB select
  logic                  penable;            // APB access phase
  logic                  pwrite;             // APB direction
  logic [PMS_DATA_W-1:0] pwdata;             // APB write data
  logic [3:0]            pstrb;              // Byte strobes
  logic [PMS_DATA_W-1:0] prdata;             // APB read data
  logic                  pready;             // APB ready
  logic                  pslverr;            // APB error
  logic                  other_reset_n;      // Soft reset, active low
  logic                  warning_below;      // Supply under warning point
  logic                  stop_request;       // Stop instruction
  logic [3:0]            wk;                 // Wake sources: reset, kbd, periodic, ext
  logic                  detect_trip_select; // Detect threshold output
  logic                  warning_trip_select;// Warning threshold output
  logic [1:0]            stop_state;         // Stop mode state
  logic                  wake_por;           // Exit acting as power-on reset
  logic                  wake_vector;        // Exit through interrupt vector
  logic                  irq;                // Interrupt line
  int                    fail_count;         // Mismatches seen
  int                    compares;           // Comparisons made
  logic [31:0]           rdv;                // Last read data
  logic                  err;                // Last error response

  pms_power_mgmt dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .other_reset_n(other_reset_n), .warning_below(warning_below),
    .stop_request(stop_request), .ext_irq(wk[0]), .periodic_wakeup(wk[1]),
    .keyboard_interrupt(wk[2]), .wake_reset(wk[3]), .detect_trip_select(detect_trip_select),
    .warning_trip_select(warning_trip_select), .stop_state(stop_state), .wake_por(wake_por),
    .wake_vector(wake_vector), .irq(irq)
  );

  // Free-running bus clock
  always begin
    #20 pclk = ~pclk;
  end

  // Compare one value and count it
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write a register
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  // Read a register and compare, no error expected
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(n, e, rdv);
    chk("pslverr", 32'h0, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
  endtask : rd

  // Stop request pulse, then the state it lands in
  task automatic enter(input logic [1:0] st);
    @(posedge pclk);
    stop_request <= 1'b1;
    @(posedge pclk);
    stop_request <= 1'b0;
    #1;
    chk("stop_state", {30'h0, st}, {30'h0, stop_state});
  endtask : enter

  // One-cycle wake pulse, then state and exit pulses
  task automatic wake(input logic [3:0] src, input logic [1:0] st, input logic por, input logic vec);
    @(posedge pclk);
    wk <= src;
    @(posedge pclk);
    wk <= 4'h0;
    #1;
    chk("stop_state", {30'h0, st}, {30'h0, stop_state});
    chk("wake_por", {31'h0, por}, {31'h0, wake_por});
    chk("wake_vector", {31'h0, vec}, {31'h0, wake_vector});
  endtask : wake

  // Counts, then the verdict
  task automatic results;
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    results();
  end

  // Main sequence
  initial begin
    pclk          = 1'b0;
    presetn       = 1'b0;
    paddr         = '0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    pwdata        = '0;
    pstrb         = 4'hf;
    other_reset_n = 1'b1;
    warning_below = 1'b0;
    stop_request  = 1'b0;
    wk            = 4'h0;
    fail_count    = 0;
    compares      = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, acks read zero
    rd("ctrl", PMS_ADDR_CTRL, 32'h0);
    rd("mask", PMS_ADDR_MASK, 32'h0);
    $display("test reset done");
    // First write sticks for once bits; selects follow every write
    wr(PMS_ADDR_CTRL, 32'h73);
    rd("ctrl", PMS_ADDR_CTRL, 32'h33);
    chk("detect_sel", 32'h1, {31'h0, detect_trip_select});
    chk("warn_sel", 32'h1, {31'h0, warning_trip_select});
    wr(PMS_ADDR_CTRL, 32'h00);
    rd("ctrl", PMS_ADDR_CTRL, 32'h03);
    chk("detect_sel", 32'h0, {31'h0, detect_trip_select});
    chk("warn_sel", 32'h0, {31'h0, warning_trip_select});
    $display("test write_once done");
    // Warning flag, ack refused while condition present, interrupt
    wr(PMS_ADDR_MASK, 32'h1);
    warning_below <= 1'b1;
    rd("ctrl", PMS_ADDR_CTRL, 32'h83);
    chk("irq", 32'h1, {31'h0, irq});
    wr(PMS_ADDR_CTRL, 32'h43);
    rd("ctrl", PMS_ADDR_CTRL, 32'h83);
    warning_below <= 1'b0;
    wr(PMS_ADDR_CTRL, 32'h40);
    rd("ctrl", PMS_ADDR_CTRL, 32'h03);
    rd("status", PMS_ADDR_STAT, 32'h1);
    rd("status", PMS_ADDR_STAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test warning done");
    // Stop2: keyboard refused, periodic wake acts as power-on reset
    enter(PMS_STOP2);
    wake(4'h4, PMS_STOP2, 1'b0, 1'b0);
    wake(4'h2, PMS_RUN, 1'b1, 1'b0);
    rd("ctrl", PMS_ADDR_CTRL, 32'h08);
    wr(PMS_ADDR_CTRL, 32'h04);
    rd("ctrl", PMS_ADDR_CTRL, 32'h00);
    $display("test stop2 done");
    // Stop3 with power down off: vector exit, then reset exit
    wr(PMS_ADDR_MASK, 32'h2);
    enter(PMS_STOP3);
    wake(4'h4, PMS_RUN, 1'b0, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    rd("status", PMS_ADDR_STAT, 32'h2);
    enter(PMS_STOP3);
    wake(4'h8, PMS_RUN, 1'b1, 1'b0);
    rd("ctrl", PMS_ADDR_CTRL, 32'h00);
    $display("test stop3 done");
    // Soft reset keeps selects, frees once bits
    wr(PMS_ADDR_CTRL, 32'h30);
    @(posedge pclk);
    other_reset_n <= 1'b0;
    @(posedge pclk);
    other_reset_n <= 1'b1;
    rd("ctrl", PMS_ADDR_CTRL, 32'h30);
    chk("detect_sel", 32'h1, {31'h0, detect_trip_select});
    rd("mask", PMS_ADDR_MASK, 32'h0);
    // Stop1: periodic and keyboard refused, external interrupt exits
    wr(PMS_ADDR_CTRL, 32'h02);
    rd("ctrl", PMS_ADDR_CTRL, 32'h02);
    enter(PMS_STOP1);
    wake(4'h6, PMS_STOP1, 1'b0, 1'b0);
    wake(4'h1, PMS_RUN, 1'b1, 1'b0);
    $display("test stop1 done");
    // Power-on reset with the supply already low must leave the flag set
    @(posedge pclk);
    presetn       <= 1'b0;
    warning_below <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", PMS_ADDR_CTRL, 32'h80);
    warning_below <= 1'b0;
    $display("test por_low done");
    // Unmapped address answers with an error and zero data
    apb(12'h00c, 1'b0, 32'h0);
    chk("unmapped data", 32'h0, rdv);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test unmapped done");
    results();
  end
endmodule : pms_power_mgmt_bench

/* File: src/pms_once_reg.sv */
`timescale 1ns/10ps
// Write-once holding register: first write after a reset sticks
module pms_once_reg
  import pms_pkg::*;
#(
  parameter int         W     = 2,
  parameter logic [1:0] RST_V = PMS_ONCE_RST
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q,
  output logic              locked
);
  logic [W-1:0] next_q;       // Next held value
  logic         next_locked;  // Next lock state

  // Later writes are dropped so a stray store cannot change the setting
  always_comb begin
    next_q      = q;
    next_locked = locked;
    if (clr) begin
      next_q      = RST_V[W-1:0];
      next_locked = 1'b0;
    end else if (wr && !locked) begin
      next_q      = wdata;
      next_locked = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= RST_V[W-1:0];
      locked <= 1'b0;
    end else begin
      q      <= next_q;
      locked <= next_locked;
    end
  end
endmodule : pms_once_reg

/* File: src/pms_pkg.sv */
package pms_pkg;
  // Register byte addresses on the APB word grid
  localparam logic [11:0] PMS_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] PMS_ADDR_STAT   = 12'h004;
  localparam logic [11:0] PMS_ADDR_MASK   = 12'h008;
  localparam int          PMS_ADDR_W      = 12;
  localparam int          PMS_DATA_W      = 32;
  localparam int          PMS_REG_W       = 8;
  // Control register field positions
  localparam int          PMS_B_WARN_FLAG = 7;
  localparam int          PMS_B_WARN_ACK  = 6;
  localparam int          PMS_B_DET_SEL   = 5;
  localparam int          PMS_B_WARN_SEL  = 4;
  localparam int          PMS_B_PPD_FLAG  = 3;
  localparam int          PMS_B_PPD_ACK   = 2;
  localparam int          PMS_B_PD_EN     = 1;
  localparam int          PMS_B_PART_SEL  = 0;
  // Interrupt status and mask field positions
  localparam int          PMS_S_WARN      = 0;
  localparam int          PMS_S_WAKE      = 1;
  localparam int          PMS_IRQ_W       = 2;
  // Reset values
  localparam logic [1:0]  PMS_ONCE_RST    = 2'h0;
  localparam logic [1:0]  PMS_IRQ_RST     = 2'h0;
  // Stop mode states, Gray ordered
  typedef enum logic [1:0] {
    PMS_RUN   = 2'h0,
    PMS_STOP3 = 2'h1,
    PMS_STOP2 = 2'h3,
    PMS_STOP1 = 2'h2
  } pms_state_e;
endpackage : pms_pkg

/* File: src/pms_power_mgmt.sv */
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - Warning flag sets while supply below warning
// - Warning acknowledge clears only without warning condition
// - Detect select: one high, zero low
// - Warning select: one high, zero low
// - Partial flag marks recovery from stop2
// - Partial acknowledge write clears partial flag
// - Power down enable permits stop1 or stop2
// - Partial select picks stop2, else stop1
// - Stop2 exits act as reset, set flag
// - Power down off means stop3, vector resume except a reset wake, which acts as reset
// - Write-once bits take first write only
module pms_power_mgmt
  import pms_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [PMS_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PMS_DATA_W-1:0] pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [PMS_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  other_reset_n,
  input  wire logic                  warning_below,
  input  wire logic                  stop_request,
  input  wire logic                  ext_irq,
  input  wire logic                  periodic_wakeup,
  input  wire logic                  keyboard_interrupt,
  input  wire logic                  wake_reset,
  output logic                       detect_trip_select,
  output logic                       warning_trip_select,
  output logic      [1:0]            stop_state,
  output logic                       wake_por,
  output logic                       wake_vector,
  output logic                       irq
);
  // Register state
  pms_state_e                state;                 // Current stop mode
  pms_state_e                next_state;            // Next stop mode
  logic                      low_warning_flag;      // Sticky warning flag
  logic                      next_low_warning_flag; // Next warning flag
  logic                      partial_power_down_flag;
  logic                      next_partial_power_down_flag;
  logic                      next_detect_trip_select;
  logic                      next_warning_trip_select;
  logic                      next_wake_por;         // Exit behaves as reset
  logic                      next_wake_vector;      // Exit through vector
  logic [PMS_IRQ_W-1:0]      irq_stat;              // Sticky event bits
  logic [PMS_IRQ_W-1:0]      next_irq_stat;
  logic [PMS_IRQ_W-1:0]      irq_mask;              // Event mask
  logic [PMS_IRQ_W-1:0]      next_irq_mask;
  logic [PMS_IRQ_W-1:0]      stat_snap;             // Status seen by a read
  logic [PMS_IRQ_W-1:0]      next_stat_snap;
  logic [PMS_DATA_W-1:0]     next_prdata;
  logic                      next_pslverr;
  // Decode and write-once wiring
  logic                      setup_ph;              // APB setup cycle
  logic                      acc_ph;                // APB access completes
  logic                      hit_ctrl;
  logic                      hit_stat;
  logic                      hit_mask;
  logic                      wr_ctrl;               // Control byte written
  logic                      rd_stat;               // Status read completes
  logic [1:0]                once_q;                // {pd enable, partial}
  logic                      once_locked;
  logic                      power_down_enable;
  logic                      partial_select;
  logic                      soft_clr;              // Any non power-on reset
  logic                      exit_any;              // Wake source seen in stop
  logic                      exit_por;              // Wake acts as power-on
  logic                      exit_from2;            // Wake leaves stop2
  logic [PMS_REG_W-1:0]      ctrl_rd;               // Control read image

  // APB phase and address decode
  assign setup_ph = psel && !penable;
  assign acc_ph   = psel && penable;
  assign hit_ctrl = (paddr == PMS_ADDR_CTRL);
  assign hit_stat = (paddr == PMS_ADDR_STAT);
  assign hit_mask = (paddr == PMS_ADDR_MASK);
  assign wr_ctrl  = acc_ph && pwrite && hit_ctrl && pstrb[0];
  assign rd_stat  = acc_ph && !pwrite && hit_stat;
  // Zero wait states: read data is staged during setup
  assign pready   = 1'b1;

  assign power_down_enable   = once_q[1];
  assign partial_select      = once_q[0];
  // Soft reset, or a wake that behaves as power-on, reloads the locks
  assign soft_clr = !other_reset_n || wake_por;

  // Write-once stop configuration
  pms_once_reg #(
    .W     (2),
    .RST_V (PMS_ONCE_RST)
  ) u_once (
    .clk    (pclk),
    .rst_n  (presetn),
    .clr    (soft_clr),
    .wr     (wr_ctrl),
    .wdata  ({pwdata[PMS_B_PD_EN], pwdata[PMS_B_PART_SEL]}),
    .q      (once_q),
    .locked (once_locked)
  );

  // Control read image; acknowledge positions always zero
  always_comb begin
    ctrl_rd                  = '0;
    ctrl_rd[PMS_B_WARN_FLAG] = low_warning_flag;
    ctrl_rd[PMS_B_DET_SEL]   = detect_trip_select;
    ctrl_rd[PMS_B_WARN_SEL]  = warning_trip_select;
    ctrl_rd[PMS_B_PPD_FLAG]  = partial_power_down_flag;
    ctrl_rd[PMS_B_PD_EN]     = power_down_enable;
    ctrl_rd[PMS_B_PART_SEL]  = partial_select;
    ctrl_rd[PMS_B_WARN_ACK]  = 1'b0;
    ctrl_rd[PMS_B_PPD_ACK]   = 1'b0;
  end

  // Wake source qualification per stop mode
  always_comb begin
    exit_any   = 1'b0;
    exit_por   = 1'b0;
    exit_from2 = 1'b0;
    case (state)
      PMS_STOP1: begin
        exit_any = ext_irq || wake_reset;
        exit_por = exit_any;
      end
      PMS_STOP2: begin
        exit_any   = ext_irq || wake_reset || periodic_wakeup;
        exit_por   = exit_any;
        exit_from2 = exit_any;
      end
      PMS_STOP3: begin
        exit_any = ext_irq || wake_reset || periodic_wakeup || keyboard_interrupt;
        exit_por = wake_reset;
      end
      default: begin
        exit_any = 1'b0;
      end
    endcase
  end

  // Stop mode sequencing
  always_comb begin
    next_state       = state;
    next_wake_por    = exit_por;
    next_wake_vector = exit_any && !exit_por;
    case (state)
      PMS_RUN: begin
        if (stop_request) begin
          if (!power_down_enable) begin
            next_state = PMS_STOP3;
          end else if (partial_select) begin
            next_state = PMS_STOP2;
          end else begin
            next_state = PMS_STOP1;
          end
        end
      end
      PMS_STOP3, PMS_STOP2, PMS_STOP1: begin
        if (exit_any) begin
          next_state = PMS_RUN;
        end
      end
      default: begin
        next_state = PMS_RUN;
      end
    endcase
    if (!other_reset_n) begin
      next_state       = PMS_RUN;
      next_wake_por    = 1'b0;
      next_wake_vector = 1'b0;
    end
  end

  // Flags and trip selects
  always_comb begin
    next_low_warning_flag        = low_warning_flag;
    next_partial_power_down_flag = partial_power_down_flag;
    next_detect_trip_select      = detect_trip_select;
    next_warning_trip_select     = warning_trip_select;
    if (wr_ctrl) begin
      next_detect_trip_select  = pwdata[PMS_B_DET_SEL];
      next_warning_trip_select = pwdata[PMS_B_WARN_SEL];
      if (pwdata[PMS_B_WARN_ACK] && !warning_below) begin
        next_low_warning_flag = 1'b0;
      end
      if (pwdata[PMS_B_PPD_ACK]) begin
        next_partial_power_down_flag = 1'b0;
      end
    end
    // Soft reset keeps the trip selects
    if (!other_reset_n) begin
      next_low_warning_flag        = 1'b0;
      next_partial_power_down_flag = 1'b0;
    end
    // Power-on style wake clears all, stop2 leaves its mark
    if (exit_por && other_reset_n) begin
      next_low_warning_flag        = 1'b0;
      next_detect_trip_select      = 1'b0;
      next_warning_trip_select     = 1'b0;
      next_partial_power_down_flag = exit_from2;
    end
    // Condition present always wins, also right after any reset
    if (warning_below) begin
      next_low_warning_flag = 1'b1;
    end
  end

  // Interrupt status, mask and APB read staging
  always_comb begin
    next_irq_stat  = irq_stat;
    next_irq_mask  = irq_mask;
    next_stat_snap = stat_snap;
    next_prdata    = prdata;
    next_pslverr   = pslverr;
    // Clear only what the read actually returned
    if (rd_stat) begin
      next_irq_stat = irq_stat & ~stat_snap;
    end
    // Set after clear so a same-cycle event is kept
    if (warning_below && !low_warning_flag) begin
      next_irq_stat[PMS_S_WARN] = 1'b1;
    end
    if (next_wake_vector) begin
      next_irq_stat[PMS_S_WAKE] = 1'b1;
    end
    if (acc_ph && pwrite && hit_mask && pstrb[0]) begin
      next_irq_mask = pwdata[PMS_IRQ_W-1:0];
    end
    if (setup_ph) begin
      next_prdata    = '0;
      next_stat_snap = '0;
      next_pslverr   = !(hit_ctrl || hit_stat || hit_mask);
      if (!pwrite && hit_ctrl) begin
        next_prdata[PMS_REG_W-1:0] = ctrl_rd;
      end
      if (!pwrite && hit_stat) begin
        next_prdata[PMS_IRQ_W-1:0] = irq_stat;
        next_stat_snap             = irq_stat;
      end
      if (!pwrite && hit_mask) begin
        next_prdata[PMS_IRQ_W-1:0] = irq_mask;
      end
    end
    if (!other_reset_n) begin
      next_irq_stat = PMS_IRQ_RST;
      next_irq_mask = PMS_IRQ_RST;
    end
  end

  // All state registers but the write-once pair in u_once; power-on reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                   <= PMS_RUN;
      low_warning_flag        <= 1'b0;
      partial_power_down_flag <= 1'b0;
      detect_trip_select      <= 1'b0;
      warning_trip_select     <= 1'b0;
      wake_por                <= 1'b0;
      wake_vector             <= 1'b0;
      irq_stat                <= PMS_IRQ_RST;
      irq_mask                <= PMS_IRQ_RST;
      stat_snap               <= PMS_IRQ_RST;
      prdata                  <= '0;
      pslverr                 <= 1'b0;
    end else begin
      state                   <= next_state;
      low_warning_flag        <= next_low_warning_flag;
      partial_power_down_flag <= next_partial_power_down_flag;
      detect_trip_select      <= next_detect_trip_select;
      warning_trip_select     <= next_warning_trip_select;
      wake_por                <= next_wake_por;
      wake_vector             <= next_wake_vector;
      irq_stat                <= next_irq_stat;
      irq_mask                <= next_irq_mask;
      stat_snap               <= next_stat_snap;
      prdata                  <= next_prdata;
      pslverr                 <= next_pslverr;
    end
  end

  assign stop_state = state;
  assign irq        = |(irq_stat & irq_mask);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_wr;
    wr_ctrl && other_reset_n && !exit_por;
  endsequence
  sequence s_run_stop;
    state == PMS_RUN && stop_request && other_reset_n;
  endsequence

  property p_warn_set;
    warning_below |=> low_warning_flag;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning flag not set");

  property p_warn_ack;
    s_ctrl_wr ##0 pwdata[PMS_B_WARN_ACK] |=> low_warning_flag == $past(warning_below);
  endproperty
  a_warn_ack: assert property (p_warn_ack) else $error("warning ack wrong");

  property p_det_sel;
    s_ctrl_wr |=> detect_trip_select == $past(pwdata[PMS_B_DET_SEL]);
  endproperty
  a_det_sel: assert property (p_det_sel) else $error("detect select not taken");

  property p_warn_sel;
    s_ctrl_wr |=> warning_trip_select == $past(pwdata[PMS_B_WARN_SEL]);
  endproperty
  a_warn_sel: assert property (p_warn_sel) else $error("warning select not taken");

  property p_ppd_ack;
    s_ctrl_wr ##0 pwdata[PMS_B_PPD_ACK] |=> !partial_power_down_flag;
  endproperty
  a_ppd_ack: assert property (p_ppd_ack) else $error("partial flag not cleared");

  property p_pd_mode;
    s_run_stop ##0 power_down_enable |=> state == ($past(partial_select) ? PMS_STOP2 : PMS_STOP1);
  endproperty
  a_pd_mode: assert property (p_pd_mode) else $error("wrong power down mode");

  property p_stop1_exit;
    state == PMS_STOP1 && other_reset_n && (ext_irq || wake_reset)
      |=> wake_por && !partial_power_down_flag ##1 !wake_por;
  endproperty
  a_stop1_exit: assert property (p_stop1_exit) else $error("stop1 exit wrong");

  property p_stop2_exit;
    state == PMS_STOP2 && other_reset_n && periodic_wakeup
      |=> wake_por && partial_power_down_flag && state == PMS_RUN;
  endproperty
  a_stop2_exit: assert property (p_stop2_exit) else $error("stop2 exit wrong");

  property p_stop3;
    s_run_stop ##0 !power_down_enable |=> state == PMS_STOP3;
  endproperty
  a_stop3: assert property (p_stop3) else $error("stop3 not used");

  property p_stop3_vec;
    state == PMS_STOP3 && other_reset_n && keyboard_interrupt && !wake_reset
      |=> wake_vector && !wake_por;
  endproperty
  a_stop3_vec: assert property (p_stop3_vec) else $error("stop3 vector exit wrong");

  property p_once;
    once_locked && !soft_clr |=> $stable(once_q);
  endproperty
  a_once: assert property (p_once) else $error("write-once bits changed");

  property p_ack_zero;
    setup_ph && !pwrite && hit_ctrl |=> prdata[PMS_B_WARN_ACK] == 1'b0 && prdata[PMS_B_PPD_ACK] == 1'b0;
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("ack bits read nonzero");

  property p_soft_keep;
    !other_reset_n && !wr_ctrl |=> $stable(detect_trip_select) && $stable(warning_trip_select);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("selects lost on soft reset");
endmodule : pms_power_mgmt
